/* File: core/ccs_pkg.sv */
// package for the cpu clock source switch: register map, fields, reset values
package ccs_pkg;
	localparam logic [11:0] OFF_CLOCK_MODE = 12'h000;
	localparam logic [11:0] OFF_CLOCK_STOP = 12'h004;
	localparam logic [11:0] OFF_SYS_CLOCK_CTRL = 12'h008;
	localparam logic [11:0] OFF_FAST_OSC_CTRL = 12'h00C;
	localparam logic [11:0] OFF_OP_SPEED_MODE = 12'h010;
	localparam logic [11:0] OFF_STAB_TIME_SEL = 12'h014;
	localparam logic [11:0] OFF_STAB_STATUS = 12'h018;
	localparam logic [11:0] OFF_POWER_CMD = 12'h01C;
	// clock_mode_reg fields
	localparam int B_EXT_CLOCK_MODE = 7;
	localparam int B_MAIN_PIN_FUNCTION = 6;
	localparam int B_SUB_PIN_FUNCTION = 4;
	localparam int B_CRYSTAL_GAIN_SELECT = 0;
	// clock_stop_reg fields
	localparam int B_MAIN_OSC_STOP = 7;
	localparam int B_SUB_OSC_STOP = 6;
	localparam int B_INTERNAL_OSC_STOP = 0;
	localparam logic [7:0] CLOCK_STOP_RESET = 8'hC0;
	// system_clock_control_reg fields
	localparam int B_CPU_SOURCE_STATUS = 7;
	localparam int B_CPU_SOURCE_SELECT = 6;
	localparam int B_MAIN_SOURCE_STATUS = 5;
	localparam int B_MAIN_SOURCE_SELECT = 4;
	localparam logic [7:0] SYS_CLOCK_CTRL_RESET = 8'h09;
	localparam logic [7:0] SYS_CLOCK_WRITE_MASK = 8'h5F;
	// fast_osc_control_reg and op speed mode fields
	localparam int B_FAST_OSC_SELECT = 1;
	localparam int B_FAST_OSC_ENABLE = 0;
	localparam int B_HIGH_SPEED_OP_SELECT = 0;
	// power command codes
	localparam logic [1:0] CMD_HALT = 2'h1;
	localparam logic [1:0] CMD_STOP = 2'h2;
	localparam logic [1:0] CMD_WAKE = 2'h3;
	localparam int STAB_CNT_W = 8;
	typedef enum logic [3:0] {
		SRC_INTERNAL = 4'b0001,
		SRC_FAST = 4'b0010,
		SRC_MAIN = 4'b0100,
		SRC_SUB = 4'b1000
	} ccs_src_e;
	typedef enum logic [2:0] {
		PM_RUN = 3'b001,
		PM_HALT = 3'b010,
		PM_STOP = 3'b100
	} ccs_pm_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ccs_apb_req_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ccs_apb_rsp_s;
	typedef struct packed {
		logic internal_on;
		logic fast_on;
		logic main_on;
		logic main_ext;
		logic main_gain;
		logic sub_on;
	} ccs_osc_en_s;
endpackage : ccs_pkg

/* File: core/ccs_switch.sv */
// cpu clock source switch: control registers, transition guard, glitch-free selector
`timescale 1ns/1ps
`default_nettype none
// Operation
// - reset runs cpu from default internal oscillator
// - clock mode register written once only
// - fast oscillator changes pass through internal
// - no run time crystal/external swap
// - unused source may be stopped after switch
// - halt enters matching halt state
// - system clock control resets to 09h
// - status bits report current cpu source
module ccs_switch #(
	parameter int NUM_SRC = 4
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire ccs_pkg::ccs_apb_req_s APB_REQ,
	output ccs_pkg::ccs_apb_rsp_s APB_RSP,
	input wire logic [NUM_SRC-1:0] SRC_CLK,
	input wire logic [ccs_pkg::STAB_CNT_W-1:0] STAB_COUNT,
	input wire logic WAKE_EVENT,
	output ccs_pkg::ccs_osc_en_s OSC_EN,
	output logic [7:0] STAB_TIME_SELECT,
	output logic HIGH_SPEED_OP,
	output logic [NUM_SRC-1:0] SRC_GRANT,
	output ccs_pkg::ccs_pm_e POWER_MODE,
	output logic CPU_CLK_GATE
);
	import ccs_pkg::*;
	initial begin
		if (NUM_SRC != 4) $error("ccs_switch serves exactly four sources");
	end
	////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] clock_mode, next_clock_mode;
	logic mode_written, next_mode_written;
	logic [7:0] clock_stop, next_clock_stop;
	logic [7:0] sys_ctrl, next_sys_ctrl;
	logic [1:0] fast_ctrl, next_fast_ctrl;
	logic op_speed, next_op_speed;
	logic [7:0] stab_sel, next_stab_sel;
	ccs_pm_e pmode, next_pmode;
	ccs_src_e cur_src, next_cur_src;
	logic [31:0] rdata, next_rdata;
	logic slverr, next_slverr;
	// first access cycle of a read is a wait state so registered read data stands at pready
	logic rd_wait, next_rd_wait;
	logic wr_en;
	logic rd_en;
	logic [3:0] want;
	logic [3:0] ack;
	logic handover_done;
	assign wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	assign rd_en = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
	////////////////////////////////////////////////////////////////////
	// requested source from control bits
	always_comb begin
		if (sys_ctrl[B_CPU_SOURCE_SELECT])
			want = SRC_SUB;
		else if (sys_ctrl[B_MAIN_SOURCE_SELECT])
			want = SRC_MAIN;
		else if (fast_ctrl[B_FAST_OSC_SELECT])
			want = SRC_FAST;
		else
			want = SRC_INTERNAL;
	end
	assign handover_done = (ack == want);
	////////////////////////////////////////////////////////////////////
	// register writes and transition guard
	always_comb begin
		logic [7:0] w;
		logic illegal;
		w = APB_REQ.pwdata[7:0];
		illegal = 1'b0;
		next_clock_mode = clock_mode;
		next_mode_written = mode_written;
		next_clock_stop = clock_stop;
		next_sys_ctrl = sys_ctrl;
		next_fast_ctrl = fast_ctrl;
		next_op_speed = op_speed;
		next_stab_sel = stab_sel;
		next_pmode = pmode;
		next_rdata = 32'h0000_0000;
		next_slverr = 1'b0;
		next_rd_wait = rd_en && !rd_wait;
		if (handover_done) begin
			next_cur_src = ccs_src_e'(want);
		end else begin
			next_cur_src = cur_src;
		end
		if (pmode != PM_RUN && WAKE_EVENT)
			next_pmode = PM_RUN;
		if (wr_en) begin
			case (APB_REQ.paddr)
				OFF_CLOCK_MODE: begin
					// single write locks the whole mode byte at once
					if (!mode_written) begin
						next_clock_mode = w;
						next_mode_written = 1'b1;
					end else begin
						illegal = 1'b1;
					end
				end
				OFF_CLOCK_STOP: begin
					// a stop is refused while that source still feeds the cpu
					next_clock_stop[B_MAIN_OSC_STOP] = w[B_MAIN_OSC_STOP];
					next_clock_stop[B_SUB_OSC_STOP] = w[B_SUB_OSC_STOP];
					next_clock_stop[B_INTERNAL_OSC_STOP] = w[B_INTERNAL_OSC_STOP];
					if (w[B_MAIN_OSC_STOP] && cur_src == SRC_MAIN)
						next_clock_stop[B_MAIN_OSC_STOP] = 1'b0;
					if (w[B_SUB_OSC_STOP] && cur_src == SRC_SUB)
						next_clock_stop[B_SUB_OSC_STOP] = 1'b0;
					if (w[B_INTERNAL_OSC_STOP] && cur_src == SRC_INTERNAL)
						next_clock_stop[B_INTERNAL_OSC_STOP] = 1'b0;
				end
				OFF_SYS_CLOCK_CTRL: begin
					// fast oscillator must be left before main or sub is chosen
					if ((w[B_MAIN_SOURCE_SELECT] || w[B_CPU_SOURCE_SELECT])
						&& fast_ctrl[B_FAST_OSC_SELECT])
						illegal = 1'b1;
					else if (!handover_done)
						illegal = 1'b1;
					else
						next_sys_ctrl = (sys_ctrl & ~SYS_CLOCK_WRITE_MASK)
							| (w & SYS_CLOCK_WRITE_MASK);
				end
				OFF_FAST_OSC_CTRL: begin
					if (w[B_FAST_OSC_SELECT] && (sys_ctrl[B_MAIN_SOURCE_SELECT]
						|| sys_ctrl[B_CPU_SOURCE_SELECT]))
						illegal = 1'b1;
					else if (!w[B_FAST_OSC_ENABLE] && w[B_FAST_OSC_SELECT])
						illegal = 1'b1;
					else if (!w[B_FAST_OSC_ENABLE] && cur_src == SRC_FAST)
						illegal = 1'b1;
					else
						next_fast_ctrl = w[1:0];
				end
				OFF_OP_SPEED_MODE: next_op_speed = w[B_HIGH_SPEED_OP_SELECT];
				OFF_STAB_TIME_SEL: next_stab_sel = w;
				OFF_POWER_CMD: begin
					if (pmode == PM_RUN && w[1:0] == CMD_HALT)
						next_pmode = PM_HALT;
					else if (pmode == PM_RUN && w[1:0] == CMD_STOP && cur_src != SRC_SUB
						&& cur_src != SRC_FAST)
						next_pmode = PM_STOP;
					else if (w[1:0] == CMD_WAKE)
						next_pmode = PM_RUN;
				end
				default: illegal = 1'b1;
			endcase
		end
		if (rd_en) begin
			case (APB_REQ.paddr)
				OFF_CLOCK_MODE: next_rdata = {24'h00_0000, clock_mode};
				OFF_CLOCK_STOP: next_rdata = {24'h00_0000, clock_stop};
				OFF_SYS_CLOCK_CTRL: begin
					next_rdata = {24'h00_0000, sys_ctrl};
					next_rdata[B_CPU_SOURCE_STATUS] = (cur_src == SRC_SUB);
					next_rdata[B_MAIN_SOURCE_STATUS] = (cur_src == SRC_MAIN);
				end
				OFF_FAST_OSC_CTRL: next_rdata = {30'h0000_0000, fast_ctrl};
				OFF_OP_SPEED_MODE: next_rdata = {31'h0000_0000, op_speed};
				OFF_STAB_TIME_SEL: next_rdata = {24'h00_0000, stab_sel};
				OFF_STAB_STATUS: next_rdata = {24'h00_0000, STAB_COUNT};
				OFF_POWER_CMD: next_rdata = {29'h0000_0000, pmode};
				default: illegal = 1'b1;
			endcase
		end
		next_slverr = illegal;
	end
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			clock_mode <= 8'h00;
			mode_written <= 1'b0;
			clock_stop <= CLOCK_STOP_RESET;
			sys_ctrl <= SYS_CLOCK_CTRL_RESET;
			fast_ctrl <= 2'b00;
			op_speed <= 1'b0;
			stab_sel <= 8'h00;
			pmode <= PM_RUN;
			cur_src <= SRC_INTERNAL;
			rdata <= 32'h0000_0000;
			slverr <= 1'b0;
			rd_wait <= 1'b0;
		end else begin
			clock_mode <= next_clock_mode;
			mode_written <= next_mode_written;
			clock_stop <= next_clock_stop;
			sys_ctrl <= next_sys_ctrl;
			fast_ctrl <= next_fast_ctrl;
			op_speed <= next_op_speed;
			stab_sel <= next_stab_sel;
			pmode <= next_pmode;
			cur_src <= next_cur_src;
			rdata <= next_rdata;
			slverr <= next_slverr;
			rd_wait <= next_rd_wait;
		end
	end
	////////////////////////////////////////////////////////////////////
	// glitch-free selector: drop old grant on old clock, take new on new clock
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_sel
			logic others;
			logic req;
			logic s1, s2, gate;
			assign others = |(ack & ~(4'b0001 << g));
			assign req = want[g] && !others;
			always_ff @(posedge SRC_CLK[g]) begin
				if (!RESET_N) begin
					s1 <= (g == 0);
					s2 <= (g == 0);
				end else begin
					s1 <= req;
					s2 <= s1;
				end
			end
			always_ff @(negedge SRC_CLK[g]) begin
				if (!RESET_N)
					gate <= (g == 0);
				else
					gate <= s2;
			end
			assign SRC_GRANT[g] = gate;
			logic a1, a2;
			always_ff @(posedge CLK) begin
				if (!RESET_N) begin
					a1 <= (g == 0);
					a2 <= (g == 0);
				end else begin
					a1 <= gate;
					a2 <= a1;
				end
			end
			assign ack[g] = a2;
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		OSC_EN.internal_on = !clock_stop[B_INTERNAL_OSC_STOP];
		OSC_EN.fast_on = fast_ctrl[B_FAST_OSC_ENABLE];
		OSC_EN.main_on = clock_mode[B_MAIN_PIN_FUNCTION] && !clock_stop[B_MAIN_OSC_STOP]
			&& pmode != PM_STOP;
		OSC_EN.main_ext = clock_mode[B_EXT_CLOCK_MODE];
		OSC_EN.main_gain = clock_mode[B_CRYSTAL_GAIN_SELECT];
		OSC_EN.sub_on = clock_mode[B_SUB_PIN_FUNCTION] && !clock_stop[B_SUB_OSC_STOP];
	end
	assign STAB_TIME_SELECT = stab_sel;
	assign HIGH_SPEED_OP = op_speed;
	assign POWER_MODE = pmode;
	assign CPU_CLK_GATE = (pmode == PM_RUN);
	assign APB_RSP.pready = !rd_en || rd_wait;
	assign APB_RSP.pslverr = slverr && 1'b0;
	assign APB_RSP.prdata = rdata;
endmodule : ccs_switch
`default_nettype wire

/* File: test/ccs_sva.sv */
// port assertions for the cpu clock source switch
`timescale 1ns/1ps
`default_nettype none
module ccs_sva #(
	parameter int NUM_SRC = 4
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire ccs_pkg::ccs_apb_req_s APB_REQ,
	input wire ccs_pkg::ccs_apb_rsp_s APB_RSP,
	input wire ccs_pkg::ccs_osc_en_s OSC_EN,
	input wire logic [NUM_SRC-1:0] SRC_GRANT,
	input wire ccs_pkg::ccs_pm_e POWER_MODE,
	input wire logic CPU_CLK_GATE
);
	import ccs_pkg::*;
	logic acc;
	logic cm_done;
	logic next_cm_done;
	assign acc = APB_REQ.psel && APB_REQ.penable;
	// remembers that the one-shot clock mode write has happened
	always_comb next_cm_done = cm_done || (acc && APB_REQ.pwrite && APB_REQ.paddr == OFF_CLOCK_MODE);
	always_ff @(posedge CLK) cm_done <= RESET_N ? next_cm_done : 1'b0;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_settled;
		(SRC_GRANT != 4'h0 && $stable(SRC_GRANT)) [*4];
	endsequence
	sequence s_rd_ctrl;
		acc && !APB_REQ.pwrite && APB_REQ.paddr == OFF_SYS_CLOCK_CTRL;
	endsequence
	property p_reset;
		$rose(RESET_N) |-> SRC_GRANT == 4'h1 && POWER_MODE == PM_RUN && APB_RSP.prdata == 32'h0000_0000;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_onehot;
		$onehot0(SRC_GRANT);
	endproperty
	a_onehot: assert property (p_onehot) else $error("two sources granted");
	property p_halt;
		acc && APB_REQ.pwrite && APB_REQ.paddr == OFF_POWER_CMD && APB_REQ.pwdata[1:0] == CMD_HALT
			&& POWER_MODE == PM_RUN |=> POWER_MODE == PM_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not entered");
	property p_gate;
		CPU_CLK_GATE == (POWER_MODE == PM_RUN);
	endproperty
	a_gate: assert property (p_gate) else $error("cpu gate disagrees with mode");
	property p_cm_lock;
		cm_done |=> $stable({OSC_EN.main_ext, OSC_EN.main_gain});
	endproperty
	a_cm_lock: assert property (p_cm_lock) else $error("clock mode changed twice");
	property p_status;
		s_settled ##0 s_rd_ctrl |=> APB_RSP.prdata[7] == SRC_GRANT[3]
			&& (SRC_GRANT[3] || APB_RSP.prdata[5] == SRC_GRANT[2]);
	endproperty
	a_status: assert property (p_status) else $error("status bits wrong");
	property p_run_src_on;
		(SRC_GRANT & ~{OSC_EN.sub_on, OSC_EN.main_on, OSC_EN.fast_on, OSC_EN.internal_on}) == 4'h0;
	endproperty
	a_run_src_on: assert property (p_run_src_on) else $error("running source stopped");
	property p_fast_isolated;
		SRC_GRANT[1] && acc && APB_REQ.pwrite && APB_REQ.paddr == OFF_SYS_CLOCK_CTRL
			|=> (SRC_GRANT == 4'h2) [*3];
	endproperty
	a_fast_isolated: assert property (p_fast_isolated) else $error("fast left directly");
endmodule : ccs_sva
bind ccs_switch ccs_sva #(.NUM_SRC(NUM_SRC)) u_sva (.CLK(CLK), .RESET_N(RESET_N),
	.APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .OSC_EN(OSC_EN), .SRC_GRANT(SRC_GRANT),
	.POWER_MODE(POWER_MODE), .CPU_CLK_GATE(CPU_CLK_GATE));
`default_nettype wire

/* File: test/ccs_osc_model.sv */
// behavioural oscillators and stabilization counter beside the switch
`timescale 1ns/1ps
`default_nettype none
module ccs_osc_model (
	input wire ccs_pkg::ccs_osc_en_s OSC_EN,
	output logic [3:0] SRC_CLK,
	output logic [ccs_pkg::STAB_CNT_W-1:0] STAB_COUNT
);
	import ccs_pkg::*;
	initial SRC_CLK = 4'h0;
	initial STAB_COUNT = 8'h00;
	// a stopped oscillator stands low
	always #12 SRC_CLK[0] = (OSC_EN.internal_on === 1'b1) && !SRC_CLK[0];
	always #9 SRC_CLK[1] = (OSC_EN.fast_on === 1'b1) && !SRC_CLK[1];
	always #16 SRC_CLK[2] = (OSC_EN.main_on === 1'b1) && !SRC_CLK[2];
	always #400 SRC_CLK[3] = (OSC_EN.sub_on === 1'b1) && !SRC_CLK[3];
	// counter restarts while the crystal is stopped and stays idle for an external clock
	always #16 begin
		if (OSC_EN.main_on !== 1'b1 || OSC_EN.main_ext === 1'b1) STAB_COUNT = 8'h00;
		else if (STAB_COUNT != 8'hFF) STAB_COUNT = STAB_COUNT + 8'h01;
	end
endmodule : ccs_osc_model
`default_nettype wire

/* File: test/ccs_switch_bench.sv */
// self-checking bench for the cpu clock source switch
`timescale 1ns/1ps
`default_nettype none
module ccs_switch_bench;
	import ccs_pkg::*;
	logic clk;
	logic reset_n;
	logic wake;
	ccs_apb_req_s req;
	ccs_apb_rsp_s rsp;
	logic [3:0] src_clk;
	logic [7:0] stab;
	ccs_osc_en_s osc_en;
	logic [7:0] sts;
	logic hs;
	logic [3:0] grant;
	ccs_pm_e pm;
	logic gate;
	int fail_count = 0;
	int n_tests = 0;
	int k;
	ccs_switch uut (.CLK(clk), .RESET_N(reset_n), .APB_REQ(req), .APB_RSP(rsp), .SRC_CLK(src_clk),
		.STAB_COUNT(stab), .WAKE_EVENT(wake), .OSC_EN(osc_en), .STAB_TIME_SELECT(sts),
		.HIGH_SPEED_OP(hs), .SRC_GRANT(grant), .POWER_MODE(pm), .CPU_CLK_GATE(gate));
	ccs_osc_model osc (.OSC_EN(osc_en), .SRC_CLK(src_clk), .STAB_COUNT(stab));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict(input bit tmo);
		if (tmo) fail_count++;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// one transfer, then an idle cycle in which registered read data stands
	task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		int n;
		q = 32'h0000_0000;
		req <= '{1'b1, 1'b0, wr, adr, dat};
		@(posedge clk);
		req.penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (rsp.pready === 1'b1) begin
				q = rsp.prdata;
				break;
			end
		end
		if (n == 20) give_verdict(1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [11:0] adr, input logic [7:0] dat);
		logic [31:0] q;
		apb(1'b1, adr, {24'h00_0000, dat}, q);
	endtask : wr
	task automatic rd(input logic [11:0] adr, input logic [7:0] exp);
		logic [31:0] q;
		apb(1'b0, adr, 32'h0000_0000, q);
		check("read data", {24'h00_0000, exp}, q);
	endtask : rd
	task automatic wgrant(input logic [3:0] exp);
		int n;
		for (n = 0; n < 500 && grant !== exp; n++) @(posedge clk);
		if (n == 500) give_verdict(1);
		// let the grant pass the two-stage acknowledge back into the control state
		repeat (4) @(posedge clk);
		check("source grant", 32'(exp), 32'(grant));
	endtask : wgrant
	task automatic wake_check(input ccs_pm_e exp);
		check("power mode", 32'(exp), 32'(pm));
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(posedge clk);
		check("power mode", 32'(PM_RUN), 32'(pm));
	endtask : wake_check
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		wake = 1'b0;
		req = '0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(OFF_SYS_CLOCK_CTRL, 8'h09);
		wgrant(4'h1);
		wr(OFF_FAST_OSC_CTRL, 8'h01);
		repeat (20) @(posedge clk);
		wr(OFF_FAST_OSC_CTRL, 8'h03);
		wgrant(4'h2);
		wr(OFF_SYS_CLOCK_CTRL, 8'h19);
		rd(OFF_SYS_CLOCK_CTRL, 8'h09);
		wr(OFF_FAST_OSC_CTRL, 8'h01);
		wgrant(4'h1);
		wr(OFF_FAST_OSC_CTRL, 8'h00);
		check("fast enable", 32'h0000_0000, 32'(osc_en.fast_on));
		wr(OFF_CLOCK_MODE, 8'h51);
		wr(OFF_STAB_TIME_SEL, 8'h80);
		check("stab select", 32'h0000_0080, 32'(sts));
		wr(OFF_CLOCK_STOP, 8'h40);
		for (k = 0; k < 200 && stab < 8'h40; k++) @(posedge clk);
		if (k == 200) give_verdict(1);
		wr(OFF_OP_SPEED_MODE, 8'h01);
		check("high speed op", 32'h0000_0001, 32'(hs));
		wr(OFF_SYS_CLOCK_CTRL, 8'h19);
		wgrant(4'h4);
		rd(OFF_SYS_CLOCK_CTRL, 8'h39);
		wr(OFF_CLOCK_MODE, 8'hC0);
		check("ext mode", 32'h0000_0000, 32'(osc_en.main_ext));
		wr(OFF_CLOCK_STOP, 8'h41);
		wr(OFF_CLOCK_STOP, 8'hC1);
		rd(OFF_CLOCK_STOP, 8'h41);
		wr(OFF_CLOCK_STOP, 8'h01);
		repeat (50) @(posedge clk);
		wr(OFF_SYS_CLOCK_CTRL, 8'h59);
		wgrant(4'h8);
		rd(OFF_SYS_CLOCK_CTRL, 8'hD9);
		wr(OFF_POWER_CMD, 8'h02);
		check("power mode", 32'(PM_RUN), 32'(pm));
		wr(OFF_POWER_CMD, 8'h01);
		wake_check(PM_HALT);
		wr(OFF_SYS_CLOCK_CTRL, 8'h19);
		wgrant(4'h4);
		wr(OFF_CLOCK_STOP, 8'h40);
		repeat (10) @(posedge clk);
		wr(OFF_SYS_CLOCK_CTRL, 8'h09);
		wgrant(4'h1);
		wr(OFF_POWER_CMD, 8'h02);
		wake_check(PM_STOP);
		wr(12'h040, 8'h5A);
		rd(12'h040, 8'h00);
		give_verdict(0);
	end
endmodule : ccs_switch_bench
`default_nettype wire
